// file: src/fpsop_special.sv
`timescale 1ns/1ns
module fpsop_special
  import fpsop_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire fpsop_req_t req,
  output fpsop_rsp_t rsp
);

  // All state of the block; one register stage from request to answer.
  typedef struct packed
  {
    fpsop_rsp_t rsp;
  } fpsop_state_t;

  fpsop_state_t state_reg; // Registered state.
  fpsop_state_t state_next; // Next value of the state.

  // Per-operand decode, filled by the generate loop below.
  logic [1:0][63:0] op_in; // Raw operands, index 0 is j, index 1 is k.
  logic [1:0] sign_w; // Sign bit of each operand.
  logic [1:0][10:0] exp_w; // Exponent field of each operand.
  logic [1:0][51:0] coef_w; // Coefficient field of each operand.
  logic [1:0] is_zero; // Operand counts as zero, denormals included.
  logic [1:0] is_inf; // Operand is infinite.
  logic [1:0] is_qnan; // Operand is a quiet NaN.
  logic [1:0] is_snan; // Operand is a signaling NaN.
  logic [1:0][62:0] frac_w; // Hidden bit, coefficient and ten extension bits.
  fpsop_class_t [1:0] cls_w; // Class code of each operand.

  assign op_in[0] = req.op_j;
  assign op_in[1] = req.op_k;

  // Both operands are decoded by the same logic, one copy per operand.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_decode
      // Field split of the 64-bit word; there is no narrower format.
      assign sign_w[gi] = op_in[gi][SIGN_POS];
      assign exp_w[gi] = op_in[gi][EXP_HI:EXP_LO];
      assign coef_w[gi] = op_in[gi][COEF_MSB:0];
      // A zero exponent is zero whatever the coefficient, so denormals vanish.
      assign is_zero[gi] = (exp_w[gi] == EXP_ZERO);
      // Max exponent with empty coefficient is infinity.
      assign is_inf[gi] = (exp_w[gi] == EXP_MAX) && (coef_w[gi] == '0);
      // Max exponent with any coefficient bit is a NaN; its MSB says quiet.
      assign is_qnan[gi] = (exp_w[gi] == EXP_MAX) && coef_w[gi][COEF_MSB];
      assign is_snan[gi] = (exp_w[gi] == EXP_MAX) && !coef_w[gi][COEF_MSB]
                           && (coef_w[gi] != '0);
      // Zeros carry no hidden bit; everything else gets it restored.
      assign frac_w[gi] = is_zero[gi] ? '0 : {1'b1, coef_w[gi], 10'h000};

      // Class code handed back for the arithmetic cores.
      always_comb
      begin
        if (is_zero[gi])
        begin
          cls_w[gi] = CLS_ZERO;
        end
        else if (is_inf[gi])
        begin
          cls_w[gi] = CLS_INF;
        end
        else if (is_qnan[gi])
        begin
          cls_w[gi] = CLS_QNAN;
        end
        else if (is_snan[gi])
        begin
          cls_w[gi] = CLS_SNAN;
        end
        else
        begin
          cls_w[gi] = CLS_NORMAL;
        end
      end
    end
  endgenerate

  // Helper terms used by the result selection.
  logic [1:0] is_nan; // Operand is a NaN of either kind.
  logic any_nan; // At least one operand is a NaN.
  logic sign_diff; // Operand signs differ.
  logic mag_lt; // Magnitude of j is below that of k.
  logic both_zero; // Both operands are zeros of any sign.
  logic [2:0] unit_tag; // Tag of the unit that would create a NaN.

  assign is_nan = is_qnan | is_snan;
  assign any_nan = |is_nan;
  assign sign_diff = sign_w[0] ^ sign_w[1];
  assign mag_lt = op_in[0][62:0] < op_in[1][62:0];
  assign both_zero = is_zero[0] && is_zero[1];

  // Tag lookup for internally created NaNs.
  always_comb
  begin
    case (req.unit)
      UNIT_ADD: unit_tag = TAG_ADD;
      UNIT_MUL: unit_tag = TAG_MUL;
      UNIT_DIV: unit_tag = TAG_DIV;
      UNIT_SQRT: unit_tag = TAG_SQRT;
      default: unit_tag = TAG_ADD;
    endcase
  end

  // Result selection. The special cases override the core result; the
  // core result passes through when nothing special applies.
  always_comb
  begin
    state_next = state_reg;
    state_next.rsp.valid = req.valid;
    state_next.rsp.frac_j = frac_w[0];
    state_next.rsp.frac_k = frac_w[1];
    state_next.rsp.class_j = cls_w[0];
    state_next.rsp.class_k = cls_w[1];
    state_next.rsp.result = req.core_result;
    state_next.rsp.override = 1'b0;
    state_next.rsp.overflow_flag = 1'b0;
    state_next.rsp.cmp_eq = 1'b0;
    state_next.rsp.cmp_lt = 1'b0;
    state_next.rsp.cmp_unordered = 1'b0;
    // Flags follow the operands of this request only; no ordering is kept
    // across instructions, which saves a reorder queue.
    // Signaling NaN inputs raise invalid, quiet ones exceptional input.
    state_next.rsp.invalid_operation_flag = req.valid && (|is_snan);
    state_next.rsp.exceptional_input_flag = req.valid && ((|is_qnan) || (|is_inf));
    if (!req.valid)
    begin
      // Idle cycle: nothing is flagged, data fields are don't-care.
      state_next.rsp.invalid_operation_flag = 1'b0;
    end
    else if (req.unit == UNIT_CMP)
    begin
      // NaNs compare unordered: equal and less both fail.
      state_next.rsp.cmp_unordered = any_nan;
      if (!any_nan)
      begin
        // Zeros of either sign are equal.
        state_next.rsp.cmp_eq = both_zero || (req.op_j == req.op_k);
        if (both_zero)
        begin
          state_next.rsp.cmp_lt = 1'b0;
        end
        else if (sign_diff)
        begin
          state_next.rsp.cmp_lt = sign_w[0];
        end
        else
        begin
          state_next.rsp.cmp_lt = sign_w[0] ? (!mag_lt && req.op_j != req.op_k) : mag_lt;
        end
      end
      // Compares on any NaN, quiet or signaling, are invalid operations.
      state_next.rsp.invalid_operation_flag = (|is_snan) || any_nan;
    end
    else if (any_nan)
    begin
      // A NaN in gives a NaN out.
      state_next.rsp.override = 1'b1;
      if (req.unit == UNIT_DIV || req.unit == UNIT_SQRT)
      begin
        // Divide and square root return the all-ones quiet NaN.
        state_next.rsp.result = QNAN_ONES;
      end
      else if (is_nan[0] && is_nan[1] && (is_snan[0] == is_snan[1]))
      begin
        // Same type: j wins, quieted and made positive.
        state_next.rsp.result = (req.op_j | QUIET_BIT) & QNAN_ONES;
      end
      else if (is_nan[0] && is_nan[1])
      begin
        // Mixed: the signaling one wins, quieted and positive.
        state_next.rsp.result = ((is_snan[0] ? req.op_j : req.op_k) | QUIET_BIT) & QNAN_ONES;
      end
      else
      begin
        // Single NaN passes through, quieted and positive.
        state_next.rsp.result = ((is_nan[0] ? req.op_j : req.op_k) | QUIET_BIT) & QNAN_ONES;
      end
    end
    else if (req.gen_nan)
    begin
      // Core made a NaN itself: all ones with the unit tag.
      state_next.rsp.override = 1'b1;
      state_next.rsp.result = (ALL_ONES & TAG_CLEAR) | {13'h0000, unit_tag, 48'h000000000000};
    end
    else if (req.overflow)
    begin
      // Out of exponent range: signed infinity and overflow.
      state_next.rsp.override = 1'b1;
      state_next.rsp.overflow_flag = 1'b1;
      state_next.rsp.result = req.core_result[SIGN_POS] ? NEG_INF : POS_INF;
    end
    else if (req.unit == UNIT_MUL && (is_zero[0] || is_zero[1]) && !(|is_inf))
    begin
      // Zero product takes the xor of signs, so opposite signs give -0.
      state_next.rsp.override = 1'b1;
      state_next.rsp.result = sign_diff ? NEG_ZERO : POS_ZERO;
    end
    else if (req.unit == UNIT_SQRT && is_zero[0])
    begin
      // Square root of a zero keeps its sign, so -0 gives -0.
      state_next.rsp.override = 1'b1;
      state_next.rsp.result = sign_w[0] ? NEG_ZERO : POS_ZERO;
    end
    else if (req.unit == UNIT_ADD && req.exact_zero)
    begin
      // Exact zero sum is +0, or -0 under round down.
      state_next.rsp.override = 1'b1;
      state_next.rsp.result = req.round_down ? NEG_ZERO : POS_ZERO;
    end
    else if (req.norm_zero)
    begin
      // Zero significand after normalizing keeps the core's sign.
      state_next.rsp.override = 1'b1;
      state_next.rsp.result = {req.core_result[SIGN_POS], 63'h0};
    end
  end

  // State register; reset clears the answer so the outputs start quiet.
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rsp = state_reg.rsp;

endmodule

// file: shared/fpsop_pkg.sv
package fpsop_pkg;

  // Word layout: sign, exponent and coefficient positions.
  localparam int FP_W = 64;
  localparam int SIGN_POS = 63;
  localparam int EXP_HI = 62;
  localparam int EXP_LO = 52;
  localparam int EXP_W = 11;
  localparam int COEF_W = 52;
  localparam int COEF_MSB = 51;
  // Internal fraction with hidden bit, and the extension below the LSB.
  localparam int FRAC_W = 53;
  localparam int EXT_W = 10;
  localparam int WIDE_W = 63;
  // Tag field of an internally created NaN.
  localparam int TAG_HI = 50;
  localparam int TAG_LO = 48;

  localparam logic [10:0] EXP_MAX = 11'h7ff;
  localparam logic [10:0] EXP_ZERO = 11'h000;
  localparam logic [2:0] TAG_ADD = 3'h1;
  localparam logic [2:0] TAG_MUL = 3'h2;
  localparam logic [2:0] TAG_DIV = 3'h4;
  localparam logic [2:0] TAG_SQRT = 3'h5;
  localparam logic [63:0] POS_INF = 64'h7ff0000000000000;
  localparam logic [63:0] NEG_INF = 64'hfff0000000000000;
  localparam logic [63:0] POS_ZERO = 64'h0000000000000000;
  localparam logic [63:0] NEG_ZERO = 64'h8000000000000000;
  localparam logic [63:0] QNAN_ONES = 64'h7fffffffffffffff;
  localparam logic [63:0] QUIET_BIT = 64'h0008000000000000;
  localparam logic [63:0] TAG_CLEAR = 64'hfff8ffffffffffff;
  localparam logic [63:0] ALL_ONES = 64'hffffffffffffffff;

  // Unit that the operands are meant for.
  typedef enum logic [2:0]
  {
    UNIT_ADD = 3'b000,
    UNIT_MUL = 3'b001,
    UNIT_DIV = 3'b010,
    UNIT_SQRT = 3'b011,
    UNIT_CMP = 3'b100
  } fpsop_unit_t;

  // Class of one operand.
  typedef enum logic [2:0]
  {
    CLS_ZERO = 3'b000,
    CLS_NORMAL = 3'b001,
    CLS_INF = 3'b010,
    CLS_QNAN = 3'b011,
    CLS_SNAN = 3'b100
  } fpsop_class_t;

  // Request from the register files.
  typedef struct packed
  {
    logic valid;
    fpsop_unit_t unit;
    logic [63:0] op_j;
    logic [63:0] op_k;
    logic round_down;
    logic exact_zero;
    logic gen_nan;
    logic overflow;
    logic norm_zero;
    logic [63:0] core_result;
  } fpsop_req_t;

  // Answer to the register files.
  typedef struct packed
  {
    logic valid;
    logic [63:0] result;
    logic override;
    logic [62:0] frac_j;
    logic [62:0] frac_k;
    fpsop_class_t class_j;
    fpsop_class_t class_k;
    logic cmp_eq;
    logic cmp_lt;
    logic cmp_unordered;
    logic invalid_operation_flag;
    logic exceptional_input_flag;
    logic overflow_flag;
  } fpsop_rsp_t;

endpackage

// file: dv/fpsop_special_asserts.sv
`timescale 1ns/1ns
// Watches the block's ports and ties each answer to the request one edge earlier.
module fpsop_special_asserts
  import fpsop_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire fpsop_req_t req,
  input wire fpsop_rsp_t rsp
);
  // One clock domain, so one default clock and one reset guard.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // True for a word with the top exponent and a nonzero coefficient.
  function automatic logic nan_of(logic [63:0] x);
    return x[62:52] == EXP_MAX && x[51:0] != 52'h0;
  endfunction

  // A request for an arithmetic unit that carries at least one NaN.
  sequence s_nan_req;
    req.valid && req.unit != UNIT_CMP && (nan_of(req.op_j) || nan_of(req.op_k));
  endsequence

  // A request for a divide or square root with a NaN operand.
  sequence s_divsqrt_nan;
    s_nan_req ##0 (req.unit == UNIT_DIV || req.unit == UNIT_SQRT);
  endsequence

  chk_answer_follows: assert property (req.valid |=> rsp.valid)
    else $error("answer did not follow request");
  chk_nan_result: assert property (s_nan_req |=> nan_of(rsp.result))
    else $error("nan operand gave a non-nan result");
  chk_snan_invalid: assert property (
    req.valid && nan_of(req.op_j) && !req.op_j[51] |=> rsp.invalid_operation_flag)
    else $error("signaling nan did not raise invalid");
  chk_qnan_exceptional: assert property (
    req.valid && nan_of(req.op_k) && req.op_k[51] |=> rsp.exceptional_input_flag)
    else $error("quiet nan did not raise exceptional input");
  chk_divsqrt_ones: assert property (s_divsqrt_nan |=> rsp.result[62:0] == QNAN_ONES[62:0])
    else $error("divide or sqrt nan not all ones");
  chk_zero_class: assert property (req.valid && req.op_j[62:52] == EXP_ZERO
    |=> rsp.class_j == CLS_ZERO && rsp.frac_j == 63'h0)
    else $error("zero exponent not classed as zero");
  chk_inf_class: assert property (req.valid && req.op_k[62:52] == EXP_MAX
    && req.op_k[51:0] == 52'h0 |=> rsp.class_k == CLS_INF)
    else $error("infinity not classed as infinity");
  chk_frac_hidden: assert property (req.valid && req.op_j[62:52] != EXP_ZERO
    |=> rsp.frac_j == {1'b1, $past(req.op_j[51:0]), 10'h000})
    else $error("fraction lacks hidden one or extension");
  chk_cmp_unordered: assert property (req.valid && req.unit == UNIT_CMP && nan_of(req.op_j)
    |=> rsp.cmp_unordered && !rsp.cmp_eq)
    else $error("nan compare not unordered");
endmodule

bind fpsop_special fpsop_special_asserts u_chk (.clock(clock), .rstn(rstn), .req(req), .rsp(rsp));

// file: dv/fpsop_regfile_model.sv
`timescale 1ns/1ns
// Register-file side: hands an operand pair to the block one edge after issue.
module fpsop_regfile_model
  import fpsop_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire fpsop_req_t issue,
  output fpsop_req_t req
);
  // A registered read port, so the block never sees a value mid-change.
  always_ff @(posedge clock)
  begin
    req <= rstn ? issue : '0;
  end
endmodule

// file: dv/fpsop_special_tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
// Drives requests through the register-file model and judges each answer.
module fpsop_special_tb
  import fpsop_pkg::*;
;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  fpsop_req_t issue = '0; // Request handed to the register-file model.
  fpsop_req_t req; // Request as the block sees it.
  fpsop_rsp_t rsp; // Answer of the block.
  int n_fail = 0;
  int num_checks = 0;
  localparam logic [63:0] ONE = 64'h3ff0000000000000;
  localparam logic [63:0] QN = 64'hfff8000000000001; // Negative quiet NaN.
  localparam logic [63:0] SN = 64'h7ff0000000000005;

  fpsop_regfile_model i_rf (.clock(clock), .rstn(rstn), .issue(issue), .req(req));
  fpsop_special i_dut (.clock(clock), .rstn(rstn), .req(req), .rsp(rsp));

  // Clock of 50 ns period.
  initial
  begin
    forever #25 clock = ~clock;
  end

  // Builds a plain request; scenarios then set the core's side flags.
  function automatic fpsop_req_t mk(fpsop_unit_t u, logic [63:0] j, logic [63:0] k);
    mk = '0;
    mk.valid = 1'b1;
    mk.unit = u;
    mk.op_j = j;
    mk.op_k = k;
  endfunction

  // Issue one request, then sample once the answer has settled.
  task automatic run(input fpsop_req_t r);
    @(posedge clock);
    issue <= r;
    @(posedge clock);
    issue <= '0;
    @(posedge clock);
    #1;
  endtask

  // Classification of denormal, infinity and quiet NaN; fraction of a normal.
  task automatic t_class();
    run(mk(UNIT_MUL, 64'h800fffffffffffff, ONE));
    `CHK("class_j", CLS_ZERO, rsp.class_j)
    `CHK("frac_k", 63'h4000000000000000, rsp.frac_k)
    run(mk(UNIT_MUL, NEG_INF, QN));
    `CHK("class_j", CLS_INF, rsp.class_j)
    `CHK("class_k", CLS_QNAN, rsp.class_k)
    `CHK("xi", 1'b1, rsp.exceptional_input_flag)
    `CHK("result", 64'h7ff8000000000001, rsp.result)
  endtask

  // NaN selection by the add and multiply units.
  task automatic t_nan();
    run(mk(UNIT_ADD, QN, SN));
    `CHK("result", 64'h7ff8000000000005, rsp.result)
    `CHK("override", 1'b1, rsp.override)
    `CHK("valid", 1'b1, rsp.valid)
    `CHK("invalid", 1'b1, rsp.invalid_operation_flag)
    run(mk(UNIT_ADD, QN, 64'hfff8000000000002));
    `CHK("result", 64'h7ff8000000000001, rsp.result)
    run(mk(UNIT_MUL, SN, ONE));
    `CHK("result", 64'h7ff8000000000005, rsp.result)
  endtask

  // Divide and square root return the all-ones quiet NaN; tags for made NaNs.
  task automatic t_div_tag();
    fpsop_req_t r;
    logic [2:0] tg[4] = '{TAG_ADD, TAG_MUL, TAG_DIV, TAG_SQRT};
    for (int i = 0; i < 4; i++)
    begin
      r = mk(fpsop_unit_t'(i), ONE, ONE);
      r.gen_nan = 1'b1;
      run(r);
      `CHK("tag", TAG_CLEAR | {13'h0, tg[i], 48'h0}, rsp.result)
      run(mk(fpsop_unit_t'(i | 2), SN, ONE));
      `CHK("ones", QNAN_ONES[62:0], rsp.result[62:0])
    end
  endtask

  // Compare with NaN and with zeros of both signs.
  task automatic t_cmp();
    run(mk(UNIT_CMP, QN, QN));
    `CHK("eq", 1'b0, rsp.cmp_eq)
    `CHK("unord", 1'b1, rsp.cmp_unordered)
    run(mk(UNIT_CMP, POS_ZERO, NEG_ZERO));
    `CHK("eq", 1'b1, rsp.cmp_eq)
    `CHK("lt", 1'b0, rsp.cmp_lt)
    run(mk(UNIT_CMP, 64'hbff0000000000000, ONE));
    `CHK("eq", 1'b0, rsp.cmp_eq)
    `CHK("lt", 1'b1, rsp.cmp_lt)
    `CHK("unord", 1'b0, rsp.cmp_unordered)
  endtask

  // Signs of zero results and overflow to infinity.
  task automatic t_zero_ovf();
    fpsop_req_t r;
    run(mk(UNIT_MUL, ONE, NEG_ZERO));
    `CHK("result", NEG_ZERO, rsp.result)
    run(mk(UNIT_SQRT, NEG_ZERO, POS_ZERO));
    `CHK("result", NEG_ZERO, rsp.result)
    for (int i = 0; i < 2; i++)
    begin
      r = mk(UNIT_ADD, ONE, 64'hbff0000000000000);
      r.exact_zero = 1'b1;
      r.round_down = i[0];
      run(r);
      `CHK("result", i ? NEG_ZERO : POS_ZERO, rsp.result)
    end
    r = mk(UNIT_ADD, ONE, ONE);
    r.norm_zero = 1'b1;
    r.core_result = 64'h8000000000001234;
    run(r);
    `CHK("result", NEG_ZERO, rsp.result)
    r.norm_zero = 1'b0;
    r.overflow = 1'b1;
    run(r);
    `CHK("result", NEG_INF, rsp.result)
    `CHK("ovf", 1'b1, rsp.overflow_flag)
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence: reset for 16 cycles, then every scenario in turn.
  initial
  begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    t_class();
    t_nan();
    t_div_tag();
    t_cmp();
    t_zero_ovf();
    end_of_test();
  end

  // The tests need about 80 cycles; a hang is cut off well beyond that.
  initial
  begin
    repeat (2000) @(posedge clock);
    n_fail++;
    end_of_test();
  end
endmodule
